/* File: hdl/feature_control_two_pkg.sv */
package feature_control_two_pkg;

    // Register byte addresses on the internal register port.
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h09;
    localparam logic [7:0] ADDR_FEATURE_ONE = 8'h0D;
    localparam logic [7:0] ADDR_FEATURE_TWO = 8'h0E;
    localparam logic [7:0] ADDR_MODE = 8'h10;

    // Field positions of the second feature-control register.
    localparam int F2_SPI_TOKEN_BIT = 2;
    localparam int F2_FIFO_TOKEN_BIT = 3;
    localparam int F2_CLEAR_ON_WRITE_BIT = 4;
    localparam int F2_STREAM_BIT = 5;
    localparam int F2_EDGE_POL_BIT = 6;
    localparam int F2_ONE_SHOT_SAMPLE_MODE_EN_BIT = 7;

    // Field positions of the first feature register and the mode register.
    localparam int F1_SPI3_BIT = 5;
    localparam int F1_I2C_EN_BIT = 6;
    localparam int F1_SPI_EN_BIT = 7;
    localparam int MODE_SW_CMD_BIT = 7;
    localparam int MODE_FIELD_MSB = 2;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h7;

    // Reset values.
    localparam logic [7:0] FEATURE_ONE_RESET = 8'h00;
    localparam logic [7:0] FEATURE_TWO_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Resolution from which the token moves to the low nibble.
    localparam logic [4:0] TOKEN_HIGH_RES = 5'h0E;

    // Bits in one serial status byte.
    localparam logic [3:0] SPI_BYTE_BITS = 4'h8;

    // FIFO status token, most significant flag first.
    typedef struct packed {
        logic irq_pending_flag;
        logic queue_threshold_flag;
        logic full;
        logic empty;
    } fifo_token_type;

    typedef enum logic [0:0] {
        SHIFT_IDLE = 1'b0,
        SHIFT_BUSY = 1'b1
    } shift_state_type;

endpackage

/* File: hdl/sample_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_queue #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int PTR_W = $clog2(DEPTH),
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic stream_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o,
    output logic [CNT_W-1:0] count_o,
    output logic full_o,
    output logic empty_o
);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    // A full queue in stream mode overwrites the oldest entry and moves the read side on.
    wire do_pop = pop_i && !empty_o;
    wire do_push = push_i && (!full_o || stream_i || do_pop);
    wire drop_old = do_push && full_o && !do_pop;

    assign full_o = (count_r == DEPTH_C);
    assign empty_o = (count_r == '0);
    assign data_o = mem[rd_ptr_r];
    assign count_o = count_r;

    // The array has no reset; only entries below the count are ever read.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && do_push) begin
            mem[wr_ptr_r] <= data_i;
        end
    end

    // Pointer and count bookkeeping.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (ce_i) begin
            if (do_push) begin
                wr_ptr_r <= bump(wr_ptr_r);
            end
            if (do_pop || drop_old) begin
                rd_ptr_r <= bump(rd_ptr_r);
            end
            if (do_push && !do_pop && !drop_old) begin
                count_r <= count_r + CNT_W'(1);
            end else if (do_pop && !do_push) begin
                count_r <= count_r - CNT_W'(1);
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/feature_control_two_logic.sv */
// Function
// [RULE1] Status byte leaves on first 4-wire byte.
// [RULE2] No status byte in 3-wire or I2C.
// [RULE3] FIFO token goes into every Z read when enabled.
// [RULE4] Low resolution: token in top nibble.
// [RULE5] High resolution: token in low nibble.
// [RULE6] Token off: Z word passes unchanged.
// [RULE7] I2C read of 0x09 clears by default.
// [RULE8] Write-clear with I2C: only writes clear.
// [RULE9] Write-clear without I2C enable: reads clear.
// [RULE10] SPI clears only by writing 0x09.
// [RULE11] Stream mode drops oldest when full.
// [RULE12] Without stream, full queue refuses samples.
// [RULE13] Stream needs FIFO enable set.
// [RULE14] Stream works in all wake modes, interfaces.
// [RULE15] Polarity bit picks falling or rising edge.
// [RULE16] Trigger enable turns interrupt pin input.
// [RULE17] Software uses one-shot mode, no command.
// [RULE18] Stream, polarity, enable at bits 5-7.
// [RULE19] I2C enable blocks all SPI traffic.
// [RULE20] Token flags taken at read time.
`timescale 1ns/1ps
`default_nettype none
module feature_control_two_logic
    import feature_control_two_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_via_i2c_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic spi_txn_start_i,
    input wire logic spi_bit_i,
    input wire logic [7:0] spi_status_i,
    output logic serial_out_addr_pin_o,
    output logic serial_out_addr_pin_oe_o,
    input wire logic irq_event_i,
    output logic irq_clear_o,
    input wire logic irq_pin_low_active_i,
    output logic irq_pin_low_active_o,
    output logic irq_pin_low_active_oe_o,
    output logic outside_sample_o,
    input wire logic fifo_enable_i,
    input wire logic sample_valid_i,
    input wire logic [47:0] sample_i,
    input wire logic [CNT_W-1:0] threshold_level_i,
    input wire logic [4:0] resolution_bits_i,
    input wire logic fifo_pop_i,
    output logic [15:0] x_word_o,
    output logic [15:0] y_word_o,
    output logic [15:0] z_word_o,
    output logic [CNT_W-1:0] fifo_count_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    logic [7:0] feature_one_r;
    logic [7:0] feature_control_two_r;
    logic [7:0] mode_r;
    logic irq_pending_r;
    logic irq_clear_r;
    logic [7:0] rdata_r;
    shift_state_type shift_state_r;
    shift_state_type shift_state_nxt;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic pin_prev_r;
    logic one_shot_sample_mode_r;
    logic irq_oe_r;
    logic [15:0] x_r;
    logic [15:0] y_r;
    logic [15:0] z_r;
    logic [47:0] q_data;
    logic [CNT_W-1:0] q_count;
    logic q_full;
    logic q_empty;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // Named fields of the stored registers.
    wire spi_token_en = feature_control_two_r[F2_SPI_TOKEN_BIT];
    wire fifo_token_en = feature_control_two_r[F2_FIFO_TOKEN_BIT];
    wire irq_clear_on_write_enable = feature_control_two_r[F2_CLEAR_ON_WRITE_BIT];
    wire stream_bit = feature_control_two_r[F2_STREAM_BIT]; // RULE18
    wire outside_sample_edge_polarity = feature_control_two_r[F2_EDGE_POL_BIT]; // RULE18
    wire outside_sample_input_enable = feature_control_two_r[F2_ONE_SHOT_SAMPLE_MODE_EN_BIT]; // RULE18
    wire i2c_enable = feature_one_r[F1_I2C_EN_BIT];
    wire spi_enable = feature_one_r[F1_SPI_EN_BIT];
    wire spi_three_wire = feature_one_r[F1_SPI3_BIT];
    wire one_shot_sample_mode = (mode_r[MODE_FIELD_MSB:0] == MODE_ONE_SHOT);
    wire software_sample_command = mode_r[MODE_SW_CMD_BIT];

    // An I2C enable shuts out SPI, and an SPI enable shuts out I2C.
    wire access_ok = reg_via_i2c_i ? !spi_enable : !i2c_enable; // RULE19
    wire wr_ok = ce_i && reg_wr_i && access_ok;
    wire rd_ok = ce_i && reg_rd_i && access_ok;

    // Interrupt clearing: any accepted write to 0x09 clears; an I2C read clears
    // unless write-clear is on while I2C is the enabled interface. SPI reads never clear.
    wire wr_status = wr_ok && hit(reg_addr_i, ADDR_IRQ_STATUS); // RULE10
    wire rd_status = rd_ok && hit(reg_addr_i, ADDR_IRQ_STATUS);
    wire rd_clears = reg_via_i2c_i && !(irq_clear_on_write_enable && i2c_enable); // RULE7 RULE8 RULE9
    wire clear_now = wr_status || (rd_status && rd_clears);

    // Read data multiplexer; the mode register is write-only and reads as zero.
    wire [7:0] rdata_nxt = hit(reg_addr_i, ADDR_FEATURE_ONE) ? feature_one_r :
                           hit(reg_addr_i, ADDR_FEATURE_TWO) ? feature_control_two_r :
                           hit(reg_addr_i, ADDR_IRQ_STATUS) ? {7'h00, irq_pending_r} :
                           8'h00;

    // Register writes.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            feature_one_r <= FEATURE_ONE_RESET;
            feature_control_two_r <= FEATURE_TWO_RESET;
            mode_r <= MODE_RESET;
        end else if (wr_ok) begin
            if (hit(reg_addr_i, ADDR_FEATURE_ONE)) begin
                feature_one_r <= reg_wdata_i;
            end
            if (hit(reg_addr_i, ADDR_FEATURE_TWO)) begin
                feature_control_two_r <= reg_wdata_i;
            end
            if (hit(reg_addr_i, ADDR_MODE)) begin
                mode_r <= reg_wdata_i;
            end
        end
    end

    // Read data and interrupt state; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= 8'h00;
            irq_pending_r <= 1'b0;
            irq_clear_r <= 1'b0;
        end else if (ce_i) begin
            if (rd_ok) begin
                rdata_r <= rdata_nxt;
            end
            irq_pending_r <= irq_event_i || (irq_pending_r && !clear_now);
            irq_clear_r <= clear_now;
        end
    end

    // Clearing checks and the SPI lock check; each looks one cycle after the access it watches.
    a_read_clear: assert property ( // RULE7
        rd_status && reg_via_i2c_i && !irq_clear_on_write_enable |=> irq_clear_o)
        else $error("I2C read of status did not clear");
    a_write_clear_only: assert property ( // RULE8
        rd_status && reg_via_i2c_i && !wr_status && irq_clear_on_write_enable
        && i2c_enable && !spi_enable |=> !irq_clear_o)
        else $error("read cleared in write-clear mode");
    a_fallback_clear: assert property ( // RULE9
        rd_status && reg_via_i2c_i && !i2c_enable |=> irq_clear_o)
        else $error("I2C read did not clear without I2C enable");
    a_spi_read_keep: assert property ( // RULE10
        rd_status && !reg_via_i2c_i && !wr_status |=> !irq_clear_o)
        else $error("SPI read cleared interrupts");
    a_spi_write_clear: assert property ( // RULE10
        wr_status |=> irq_clear_o)
        else $error("write to status did not clear");
    a_spi_blocked: assert property ( // RULE19
        ce_i && reg_wr_i && !reg_via_i2c_i && i2c_enable |=> $stable(feature_control_two_r))
        else $error("SPI write passed I2C lock");
    // A clear must never swallow an event that arrives in the same cycle.
    a_pending_set: assert property ( // RULE7
        ce_i && irq_event_i |=> irq_pending_r)
        else $error("new event lost to a clear");

    // The status byte is only loaded for a 4-wire SPI transaction.
    wire spi_load = spi_txn_start_i && spi_token_en && !spi_three_wire && !i2c_enable; // RULE1 RULE2
    wire last_bit = (bit_cnt_r == SPI_BYTE_BITS - 4'h1);

    always_comb begin
        shift_state_nxt = shift_state_r;
        unique case (shift_state_r)
            SHIFT_IDLE: begin
                if (spi_load) begin
                    shift_state_nxt = SHIFT_BUSY;
                end
            end
            SHIFT_BUSY: begin
                if (spi_bit_i && last_bit) begin
                    shift_state_nxt = SHIFT_IDLE;
                end
            end
        endcase
    end

    // Serial shifter, most significant bit first; the pin is driven only while busy.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_state_r <= SHIFT_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (ce_i) begin
            shift_state_r <= shift_state_nxt;
            if (shift_state_r == SHIFT_IDLE && spi_load) begin
                shift_r <= spi_status_i; // RULE1
                bit_cnt_r <= 4'h0;
            end else if (shift_state_r == SHIFT_BUSY && spi_bit_i) begin
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end

    assign serial_out_addr_pin_o = shift_r[7];
    assign serial_out_addr_pin_oe_o = (shift_state_r == SHIFT_BUSY);

    a_spi_token_load: assert property ( // RULE1
        ce_i && spi_load && shift_state_r == SHIFT_IDLE
        |=> serial_out_addr_pin_oe_o && serial_out_addr_pin_o == $past(spi_status_i[7]))
        else $error("status byte not presented");
    a_spi_token_end: assert property ( // RULE1
        ce_i && serial_out_addr_pin_oe_o && spi_bit_i && last_bit
        |=> !serial_out_addr_pin_oe_o)
        else $error("status byte ran past eight bits");
    a_spi_token_quiet: assert property ( // RULE2
        $rose(serial_out_addr_pin_oe_o)
        |-> $past(spi_token_en && !spi_three_wire && !i2c_enable))
        else $error("status byte sent in wrong mode");

    // Stream mode takes effect only with the FIFO enabled, in any wake mode or interface.
    wire stream_active = stream_bit && fifo_enable_i; // RULE13 RULE14
    wire push = sample_valid_i && fifo_enable_i;
    wire pop_ok = fifo_pop_i && !q_empty;

    sample_queue #(
        .WIDTH(48),
        .DEPTH(DEPTH)
    ) u_queue (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .push_i(push),
        .pop_i(fifo_pop_i),
        .stream_i(stream_active), // RULE11 RULE12
        .data_i(sample_i),
        .data_o(q_data),
        .count_o(q_count),
        .full_o(q_full),
        .empty_o(q_empty)
    );

    a_stream_drop: assert property ( // RULE11
        ce_i && q_full && push && stream_active && !fifo_pop_i
        |=> q_full && u_queue.rd_ptr_r != $past(u_queue.rd_ptr_r))
        else $error("stream mode kept the oldest sample");
    a_full_refuse: assert property ( // RULE12
        ce_i && q_full && push && !stream_active && !fifo_pop_i
        |=> q_full && $stable(q_data))
        else $error("full queue accepted sample");

    // Flags are sampled at read-out, so they describe the queue as the host sees it.
    fifo_token_type token;
    assign token.irq_pending_flag = irq_pending_r; // RULE20
    assign token.queue_threshold_flag = (q_count >= threshold_level_i);
    assign token.full = q_full;
    assign token.empty = q_empty;

    wire [15:0] z_raw = q_data[15:0];
    wire high_res = (resolution_bits_i >= TOKEN_HIGH_RES);
    wire [15:0] z_low_tok = {token, z_raw[11:0]}; // RULE4
    wire [15:0] z_high_tok = {z_raw[15:4], token}; // RULE5
    wire [15:0] z_nxt = !fifo_token_en ? z_raw : // RULE6
                        high_res ? z_high_tok : z_low_tok; // RULE3

    // Output words update on each accepted pop and hold otherwise.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            x_r <= 16'h0000;
            y_r <= 16'h0000;
            z_r <= 16'h0000;
        end else if (ce_i && pop_ok) begin
            x_r <= q_data[47:32];
            y_r <= q_data[31:16];
            z_r <= z_nxt;
        end
    end

    a_token_low: assert property ( // RULE4
        ce_i && pop_ok && fifo_token_en && !high_res
        |=> z_word_o == {$past(token), $past(z_raw[11:0])})
        else $error("low-resolution token misplaced");
    a_token_high: assert property ( // RULE5
        ce_i && pop_ok && fifo_token_en && high_res
        |=> z_word_o == {$past(z_raw[15:4]), $past(token)})
        else $error("high-resolution token misplaced");
    a_token_off: assert property ( // RULE6
        ce_i && pop_ok && !fifo_token_en |=> z_word_o == $past(z_raw))
        else $error("Z word altered with token off");

    // External trigger: edge select on the interrupt pin, only in one-shot mode
    // and never together with the software command, which would double-trigger.
    wire rise = irq_pin_low_active_i && !pin_prev_r;
    wire fall = !irq_pin_low_active_i && pin_prev_r;
    wire edge_hit = outside_sample_edge_polarity ? rise : fall; // RULE15
    wire one_shot_sample_mode_nxt = outside_sample_input_enable && one_shot_sample_mode
                    && !software_sample_command && edge_hit; // RULE17

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_prev_r <= 1'b1;
            one_shot_sample_mode_r <= 1'b0;
            irq_oe_r <= 1'b0;
        end else if (ce_i) begin
            pin_prev_r <= irq_pin_low_active_i;
            one_shot_sample_mode_r <= one_shot_sample_mode_nxt;
            irq_oe_r <= !outside_sample_input_enable && irq_pending_r; // RULE16
        end
    end

    a_one_shot_sample_mode_edge: assert property ( // RULE15
        ce_i && outside_sample_input_enable && one_shot_sample_mode
        && !software_sample_command && edge_hit |=> outside_sample_o)
        else $error("trigger edge missed");
    a_one_shot_sample_mode_wrong_edge: assert property ( // RULE15
        ce_i && outside_sample_edge_polarity && fall |=> !outside_sample_o)
        else $error("rising polarity fired on falling edge");
    a_pin_input: assert property ( // RULE16
        ce_i && outside_sample_input_enable |=> !irq_pin_low_active_oe_o)
        else $error("interrupt pin driven in trigger mode");
    a_pin_driven: assert property ( // RULE16
        ce_i && !outside_sample_input_enable && irq_pending_r |=> irq_pin_low_active_oe_o)
        else $error("pending interrupt not driven on pin");

    assign reg_rdata_o = rdata_r;
    assign irq_clear_o = irq_clear_r;
    assign irq_pin_low_active_o = 1'b0;
    assign irq_pin_low_active_oe_o = irq_oe_r;
    assign outside_sample_o = one_shot_sample_mode_r;
    assign x_word_o = x_r;
    assign y_word_o = y_r;
    assign z_word_o = z_r;
    assign fifo_count_o = q_count;
endmodule
`default_nettype wire

/* File: verification/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller model: drives register accesses and serial strobes.
module host_model (
    input wire logic clk_sys_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic via_i2c_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic [2:0] strobe_o,
    output logic [7:0] status_o
);
    // Quiet bus at time zero.
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        via_i2c_o = 1'b1;
        addr_o = 8'h00;
        wdata_o = 8'h00;
        strobe_o = 3'h0;
        status_o = 8'h00;
    end

    // One access per call; released lines show inverted data, never a stale copy.
    // Over SPI this host clears interrupts by writing, since reads there do not.
    task automatic access(input logic w, input logic i2c, input logic [7:0] a, d);
        @(posedge clk_sys_i);
        #2;
        reg_wr_o = w;
        reg_rd_o = ~w;
        via_i2c_o = i2c;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_sys_i);
        #2;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // One-cycle pulse of {start, shift, pop}.
    task automatic strobe(input logic [2:0] sel, input logic [7:0] s);
        @(posedge clk_sys_i);
        #2;
        strobe_o = sel;
        status_o = s;
        @(posedge clk_sys_i);
        #2;
        strobe_o = 3'h0;
        status_o = ~s;
    endtask
endmodule
`default_nettype wire

/* File: verification/feature_control_two_logic_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module feature_control_two_logic_tb;
    import feature_control_two_pkg::*;
    typedef struct packed {
        logic [1:0] k;
        logic [15:0] v;
    } note_type;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic reg_wr, reg_rd, via_i2c, sdo, sdo_oe, irq_clear, pin_oe, pin_lo, ext_pulse;
    logic [7:0] addr, wdata, rdata, status;
    logic [2:0] stb;
    logic [2:0] count;
    logic [15:0] xw, yw, zw;
    logic irq_event = 1'b0;
    logic pin = 1'b1;
    logic fifo_en = 1'b0;
    logic sample_valid = 1'b0;
    logic [47:0] sample = 48'h0;
    logic [4:0] res = 5'h0C;
    logic [47:0] smp[11];
    logic ce = 1'b1;
    wire pin_w = pin_oe ? pin_lo : pin;
    int errors = 0;
    int n_tests = 0;
    int n_ext = 0;
    note_type q[$];

    always #12.5 clk_sys_i = ~clk_sys_i;

    host_model i_host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .via_i2c_o(via_i2c), .addr_o(addr), .wdata_o(wdata), .strobe_o(stb),
        .status_o(status));

    // A small queue keeps the full and stream cases short.
    feature_control_two_logic #(.DEPTH(4)) i_dut (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .ce_i(ce), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_via_i2c_i(via_i2c), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .spi_txn_start_i(stb[2]), .spi_bit_i(stb[1]),
        .spi_status_i(status), .serial_out_addr_pin_o(sdo),
        .serial_out_addr_pin_oe_o(sdo_oe), .irq_event_i(irq_event),
        .irq_clear_o(irq_clear), .irq_pin_low_active_i(pin_w),
        .irq_pin_low_active_o(pin_lo), .irq_pin_low_active_oe_o(pin_oe),
        .outside_sample_o(ext_pulse), .fifo_enable_i(fifo_en),
        .sample_valid_i(sample_valid), .sample_i(sample), .threshold_level_i(3'h2),
        .resolution_bits_i(res), .fifo_pop_i(stb[0]), .x_word_o(xw), .y_word_o(yw),
        .z_word_o(zw), .fifo_count_o(count));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Just after the edge that takes a strobe, the oldest note meets the outputs.
    // Looking a cycle later would miss the one-cycle clear pulse.
    always @(posedge clk_sys_i) begin
        note_type e;
        #1;
        if (reg_wr | reg_rd | (|stb)) begin
            e = q.pop_front();
            case (e.k)
                2'h0: chk({15'h0, irq_clear}, e.v);
                2'h1: chk({7'h0, irq_clear, rdata}, e.v);
                2'h2: chk(zw, e.v);
                default: chk({14'h0, sdo_oe, sdo_oe & sdo}, e.v);
            endcase
        end
    end

    // Trigger pulses are counted just after the edge that launches them.
    always @(posedge clk_sys_i) #1 if (ext_pulse === 1'b1) n_ext++;

    task automatic wr(input logic i2c, input logic [7:0] a, d, input logic clr);
        q.push_back('{2'h0, {15'h0, clr}});
        i_host.access(1'b1, i2c, a, d);
    endtask

    task automatic rd(input logic i2c, input logic [7:0] a, d, input logic clr);
        q.push_back('{2'h1, {7'h0, clr, d}});
        i_host.access(1'b0, i2c, a, 8'h00);
    endtask

    task automatic irq;
        @(posedge clk_sys_i);
        #2;
        irq_event = 1'b1;
        @(posedge clk_sys_i);
        #2;
        irq_event = 1'b0;
    endtask

    task automatic push(input int i);
        @(posedge clk_sys_i);
        #2;
        sample_valid = 1'b1;
        sample = smp[i];
        @(posedge clk_sys_i);
        #2;
        sample_valid = 1'b0;
        sample = ~smp[i];
    endtask

    task automatic popz(input int i, input logic [15:0] z);
        q.push_back('{2'h2, z});
        i_host.strobe(3'h1, 8'h00);
        chk(xw, smp[i][47:32]);
        chk(yw, smp[i][31:16]);
    endtask

    // Status byte leaves msb first, one bit per shift pulse.
    task automatic spi(input logic four);
        logic [7:0] s;
        s = 8'($urandom);
        q.push_back('{2'h3, {14'h0, four, four & s[7]}});
        i_host.strobe(3'h4, s);
        for (int k = 1; four && k <= 8; k++) begin
            q.push_back('{2'h3, {14'h0, k < 8, (k < 8) & s[7 - k]}});
            i_host.strobe(3'h2, s);
        end
    endtask

    task automatic edge_chk(input logic lvl, input int n);
        int n0;
        n0 = n_ext;
        @(posedge clk_sys_i);
        #2;
        pin = lvl;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk(16'(n_ext - n0), 16'(n));
    endtask

    // A hung run is cut short here.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        results;
    end

    // Main sequence.
    initial begin
        logic [7:0] v;
        void'($urandom(32'h16A7));
        foreach (smp[i]) smp[i] = 48'({$urandom, $urandom});
        repeat (16) @(posedge clk_sys_i);
        #2;
        reset_n_i = 1'b1;
        rd(1'b1, ADDR_FEATURE_TWO, FEATURE_TWO_RESET, 1'b0);
        v = 8'($urandom);
        wr(1'b1, ADDR_FEATURE_TWO, v, 1'b0);
        rd(1'b0, ADDR_FEATURE_TWO, v, 1'b0);
        wr(1'b1, ADDR_FEATURE_TWO, 8'h00, 1'b0);
        irq;
        rd(1'b1, ADDR_IRQ_STATUS, 8'h01, 1'b1);
        wr(1'b1, ADDR_FEATURE_TWO, 8'h10, 1'b0);
        irq;
        rd(1'b1, ADDR_IRQ_STATUS, 8'h01, 1'b1);
        wr(1'b1, ADDR_FEATURE_ONE, 8'h40, 1'b0);
        irq;
        rd(1'b1, ADDR_IRQ_STATUS, 8'h01, 1'b0);
        wr(1'b1, ADDR_IRQ_STATUS, 8'($urandom), 1'b1);
        wr(1'b0, ADDR_FEATURE_TWO, 8'h00, 1'b0);
        rd(1'b1, ADDR_FEATURE_TWO, 8'h10, 1'b0);
        wr(1'b1, ADDR_FEATURE_ONE, 8'h80, 1'b0);
        irq;
        rd(1'b0, ADDR_IRQ_STATUS, 8'h01, 1'b0);
        wr(1'b0, ADDR_IRQ_STATUS, 8'h00, 1'b1);
        wr(1'b0, ADDR_FEATURE_TWO, 8'h04, 1'b0);
        spi(1'b1);
        wr(1'b0, ADDR_FEATURE_ONE, 8'hA0, 1'b0);
        spi(1'b0);
        wr(1'b0, ADDR_FEATURE_ONE, 8'h80, 1'b0);
        fifo_en = 1'b1;
        wr(1'b0, ADDR_FEATURE_TWO, 8'h08, 1'b0);
        for (int i = 0; i < 5; i++) push(i);
        chk({13'h0, count}, 16'h0004);
        popz(0, {4'h6, smp[0][11:0]});
        popz(1, {4'h4, smp[1][11:0]});
        popz(2, {4'h4, smp[2][11:0]});
        irq;
        popz(3, {4'h8, smp[3][11:0]});
        wr(1'b0, ADDR_FEATURE_TWO, 8'h28, 1'b0);
        res = 5'h0E;
        for (int i = 5; i < 11; i++) push(i);
        chk({13'h0, count}, 16'h0004);
        popz(7, {smp[7][15:4], 4'hE});
        wr(1'b0, ADDR_FEATURE_TWO, 8'h20, 1'b0);
        popz(8, smp[8][15:0]);
        wr(1'b0, ADDR_MODE, {5'h0, MODE_ONE_SHOT}, 1'b0);
        wr(1'b0, ADDR_FEATURE_TWO, 8'h80, 1'b0);
        @(posedge clk_sys_i);
        #1;
        chk({15'h0, pin_oe}, 16'h0000);
        edge_chk(1'b0, 1);
        edge_chk(1'b1, 0);
        wr(1'b0, ADDR_FEATURE_TWO, 8'hC0, 1'b0);
        edge_chk(1'b0, 0);
        edge_chk(1'b1, 1);
        wr(1'b0, ADDR_FEATURE_TWO, 8'h00, 1'b0);
        @(posedge clk_sys_i);
        #1;
        chk({14'h0, pin_oe, pin_w}, 16'h0002);
        #1;
        ce = 1'b0;
        wr(1'b0, ADDR_FEATURE_TWO, 8'hFF, 1'b0);
        ce = 1'b1;
        rd(1'b0, ADDR_FEATURE_TWO, 8'h00, 1'b0);
        results;
    end
endmodule
`default_nettype wire
